// file: rtl/rsc_pkg.sv
// constants, states and timing for the system reset controller
package rsc_pkg;

	// reset vector byte locations, low byte first
	localparam logic [15:0] RSC_VEC_ADDR_LO = 16'h0000;
	localparam logic [15:0] RSC_VEC_ADDR_HI = 16'h0001;

	// opcode that forces an internal reset when executed
	localparam logic [7:0]  RSC_OPCODE_ILLEGAL = 8'hff;

	// reset cause register layout and reset value
	localparam int          RSC_CAUSE_ILLEGAL_BIT = 7;
	localparam int          RSC_CAUSE_WATCHDOG_BIT = 4;
	localparam int          RSC_CAUSE_LOW_VOLTAGE_BIT = 0;
	localparam logic [7:0]  RSC_CAUSE_RESET = 8'h00;

	// clock rate and oscillation stabilization wait
	localparam int          RSC_CLK_PERIOD_NS = 25;
	localparam int          RSC_STAB_WAIT_NS = 1000;
	localparam logic [7:0]  RSC_STAB_WAIT_CYC =
		8'((RSC_STAB_WAIT_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS);

	// least low time on the reset pin, kept by the board side
	localparam int          RSC_EXT_MIN_LOW_US = 10;

	// controller states, gray coded along reset, wait, fetch, run
	typedef enum logic [1:0] {
		RSC_ST_RESET = 2'b00,
		RSC_ST_WAIT  = 2'b01,
		RSC_ST_FETCH = 2'b11,
		RSC_ST_RUN   = 2'b10
	} rsc_state_t;

	// vector fetch states, gray coded
	typedef enum logic [1:0] {
		RSC_VF_IDLE = 2'b00,
		RSC_VF_LO   = 2'b01,
		RSC_VF_HI   = 2'b11,
		RSC_VF_DONE = 2'b10
	} rsc_vf_state_t;

endpackage : rsc_pkg

// file: rtl/rsc_vec_if.sv
// handshake between the reset sequencer and the vector fetch unit
`timescale 1ns/1ps
`default_nettype none
interface rsc_vec_if;
	logic        start;
	logic        done;
	logic [15:0] pc;

	modport ctrl (output start, input done, input pc);
	modport fetch (input start, output done, output pc);
endinterface : rsc_vec_if
`default_nettype wire

// file: rtl/rsc_vector_fetch.sv
// reads the two reset vector bytes and forms the start address
`timescale 1ns/1ps
`default_nettype none
module rsc_vector_fetch (
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	rsc_vec_if.fetch           vec,
	output logic               o_mem_rd,
	output logic [15:0]        o_mem_addr,
	input  wire logic [7:0]    i_mem_rdata
);

	typedef struct packed {
		rsc_pkg::rsc_vf_state_t st;
		logic                   rd;
		logic [15:0]            addr;
		logic [15:0]            pc;
		logic                   done;
	} rsc_vf_regs_t;

	rsc_vf_regs_t r_q;
	rsc_vf_regs_t r_d;

	// read data is taken at the end of the cycle the strobe is high
	always_comb begin
		r_d      = r_q;
		r_d.rd   = 1'b0;
		r_d.done = 1'b0;
		case (r_q.st)
			rsc_pkg::RSC_VF_IDLE: begin
				if (vec.start) begin
					r_d.st   = rsc_pkg::RSC_VF_LO;
					r_d.rd   = 1'b1;
					r_d.addr = rsc_pkg::RSC_VEC_ADDR_LO;
				end
			end
			rsc_pkg::RSC_VF_LO: begin
				r_d.pc[7:0] = i_mem_rdata;
				r_d.st      = rsc_pkg::RSC_VF_HI;
				r_d.rd      = 1'b1;
				r_d.addr    = rsc_pkg::RSC_VEC_ADDR_HI;
			end
			rsc_pkg::RSC_VF_HI: begin
				r_d.pc[15:8] = i_mem_rdata;
				r_d.st       = rsc_pkg::RSC_VF_DONE;
				r_d.done     = 1'b1;
			end
			default: begin
				r_d.st = rsc_pkg::RSC_VF_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign vec.done   = r_q.done;
	assign vec.pc     = r_q.pc;
	assign o_mem_rd   = r_q.rd;
	assign o_mem_addr = r_q.addr;

endmodule : rsc_vector_fetch
`default_nettype wire

// file: rtl/rsc_system_reset_controller.sv
// system reset controller: merges reset requests and sequences release
//
// What this block does
// - five requests each cause a full chip reset.
// - after any reset start from the vector at 0000H and 0001H.
// - reset pin low holds reset; high releases onto the fast oscillator.
// - pins float during reset and the stabilization wait after it.
// - watchdog reset releases by itself, then runs on the fast oscillator.
// - supply detector resets hold until supply is good, then release.
// - executing opcode FFH raises an internal reset.
// - illegal opcode reset is blocked under debug emulation.
// - reset pin low stops all four oscillators and ignores external clock.
// - a reset ends STOP mode and runs the normal reset sequence.
// - reset out of STOP keeps RAM but reinitializes registers.
// - low voltage reset leaves the low voltage detector itself running.
// - watchdog reset also reinitializes the watchdog.
// - in reset crystal pins become inputs and the CPU clock stops.
// - in reset RAM holds above clear level; CPU, flash, RAM stop.
// - in reset clear detector runs; peripherals stop, voltage detector too unless low voltage is the only request.
// - during reset and wait only the program counter is undefined.
// - reset in standby keeps data memory and general registers.
// - cause register is 00H after pin or clear reset and after read.
`timescale 1ns/1ps
`default_nettype none
module rsc_system_reset_controller (
	input  wire logic          i_core_clk,
	input  wire logic          i_resetn,
	input  wire logic          i_ext_reset_n,
	input  wire logic          i_wdt_overflow,
	input  wire logic          i_poc_below,
	input  wire logic          i_lvd_below,
	input  wire logic          i_op_exec,
	input  wire logic [7:0]    i_op_code,
	input  wire logic          i_debug_emul,
	input  wire logic          i_stop_mode,
	input  wire logic          i_cause_read,
	input  wire logic [7:0]    i_mem_rdata,
	output logic               o_chip_reset_n,
	output logic               o_pins_hiz,
	output logic [3:0]         o_osc_stop,
	output logic               o_ext_clk_ignore,
	output logic               o_xtal_pins_input,
	output logic               o_cpu_clk_stop,
	output logic               o_core_mem_stop,
	output logic               o_ram_retain,
	output logic               o_poc_active,
	output logic               o_lvd_stop,
	output logic               o_lvd_reset_n,
	output logic               o_periph_stop,
	output logic               o_wdt_reset,
	output logic               o_stop_exit,
	output logic               o_mem_keep,
	output logic               o_pc_valid,
	output logic [15:0]        o_pc,
	output logic               o_mem_rd,
	output logic [15:0]        o_mem_addr,
	output logic [7:0]         o_reset_cause
);

	// all sequencer state in one word
	typedef struct packed {
		rsc_pkg::rsc_state_t st;
		logic [7:0]          wait_cnt;
		logic [7:0]          cause;
		logic                lvd_own;
		logic                stop_rst;
		logic                stop_exit;
		logic                vec_start;
		logic                chip_reset_n;
		logic                pins_hiz;
		logic [3:0]          osc_stop;
		logic                ext_clk_ignore;
		logic                xtal_in;
		logic                cpu_clk_stop;
		logic                core_mem_stop;
		logic                ram_retain;
		logic                poc_active;
		logic                lvd_stop;
		logic                lvd_reset_n;
		logic                periph_stop;
		logic                wdt_reset;
		logic                pc_valid;
	} rsc_regs_t;

	rsc_regs_t   r_q;
	rsc_regs_t   r_d;
	logic [1:0]  rst_sync_q;
	logic        rst_n;

	logic        req_ext;
	logic        req_poc;
	logic        req_lvd;
	logic        req_wdt;
	logic        req_ill;
	logic        any_req;
	logic        in_reset;

	rsc_vec_if vec ();

	// sequencer parked in its reset state while any request stands
	function automatic logic rsc_held(input rsc_pkg::rsc_state_t st);
		return st == rsc_pkg::RSC_ST_RESET;
	endfunction : rsc_held

	// whole reset span: reset, wait and vector fetch; only run is outside it
	function automatic logic rsc_in_span(input rsc_pkg::rsc_state_t st);
		return st != rsc_pkg::RSC_ST_RUN;
	endfunction : rsc_in_span

	// an executed illegal opcode traps unless debug emulation is on
	function automatic logic rsc_is_trap(
		input logic       exec,
		input logic [7:0] code,
		input logic       emul
	);
		return exec && (code == rsc_pkg::RSC_OPCODE_ILLEGAL) && !emul;
	endfunction : rsc_is_trap

	// the low voltage request stands alone, so its detector keeps running
	function automatic logic rsc_lvd_only(
		input logic lvd,
		input logic others
	);
		return lvd && !others;
	endfunction : rsc_lvd_only

	// next cause flags: a read clears, a new event in the same cycle wins,
	// and a pin or clear reset wipes last so it beats every set
	function automatic logic [7:0] rsc_cause_next(
		input logic [7:0] cur,
		input logic       rd,
		input logic       ill,
		input logic       wdt,
		input logic       lvd,
		input logic       wipe
	);
		logic [7:0] nxt;
		nxt = cur;
		if (rd) begin
			nxt = rsc_pkg::RSC_CAUSE_RESET;
		end
		if (ill) begin
			nxt[rsc_pkg::RSC_CAUSE_ILLEGAL_BIT] = 1'b1;
		end
		if (wdt) begin
			nxt[rsc_pkg::RSC_CAUSE_WATCHDOG_BIT] = 1'b1;
		end
		if (lvd) begin
			nxt[rsc_pkg::RSC_CAUSE_LOW_VOLTAGE_BIT] = 1'b1;
		end
		if (wipe) begin
			nxt = rsc_pkg::RSC_CAUSE_RESET;
		end
		return nxt;
	endfunction : rsc_cause_next

	// reset release through two flops; assertion stays asynchronous
	// so the rest of the block sees a release aligned to the clock, never a runt
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// request decode; all inputs are synchronous to the core clock
	always_comb begin
		req_ext = !i_ext_reset_n;
		req_poc = i_poc_below;
		req_lvd = i_lvd_below;
		req_wdt = i_wdt_overflow;
		req_ill = rsc_is_trap(i_op_exec, i_op_code, i_debug_emul);
		any_req = req_ext || req_poc || req_lvd || req_wdt || req_ill;
	end

	// next state and registered outputs
	always_comb begin
		r_d           = r_q;
		r_d.stop_exit = 1'b0;
		r_d.vec_start = 1'b0;
		in_reset      = 1'b1;

		case (r_q.st)
			rsc_pkg::RSC_ST_RESET: begin
				if (!any_req) begin
					r_d.st       = rsc_pkg::RSC_ST_WAIT;
					r_d.wait_cnt = 8'h00;
				end
			end
			rsc_pkg::RSC_ST_WAIT: begin
				if (r_q.wait_cnt == rsc_pkg::RSC_STAB_WAIT_CYC - 8'h01) begin
					r_d.st        = rsc_pkg::RSC_ST_FETCH;
					r_d.vec_start = 1'b1;
				end else begin
					r_d.wait_cnt = r_q.wait_cnt + 8'h01;
				end
			end
			rsc_pkg::RSC_ST_FETCH: begin
				if (vec.done) begin
					r_d.st = rsc_pkg::RSC_ST_RUN;
				end
			end
			default: begin
				r_d.st = rsc_pkg::RSC_ST_RUN;
			end
		endcase

		// any request restarts the sequence from any state
		if (any_req) begin
			r_d.st       = rsc_pkg::RSC_ST_RESET;
			r_d.wait_cnt = 8'h00;
			r_d.lvd_own  = rsc_lvd_only(req_lvd, req_ext || req_poc || req_wdt || req_ill);
			if (r_q.st == rsc_pkg::RSC_ST_RUN) begin
				r_d.stop_rst  = i_stop_mode;
				r_d.stop_exit = i_stop_mode;
			end
		end else if (!rsc_in_span(r_d.st)) begin
			r_d.lvd_own = 1'b0;
		end

		// cause flags: a read clears, a new event in the same cycle wins
		// cleared by read, pin and clear zero it
		r_d.cause = rsc_cause_next(r_q.cause, i_cause_read, req_ill, req_wdt, req_lvd,
			req_ext || req_poc);

		in_reset = rsc_in_span(r_d.st);

		r_d.pins_hiz = in_reset;
		r_d.chip_reset_n = !in_reset;
		r_d.osc_stop       = {4{req_ext && rsc_held(r_d.st)}};
		r_d.ext_clk_ignore = req_ext && rsc_held(r_d.st);
		r_d.xtal_in      = in_reset;
		r_d.cpu_clk_stop = in_reset;
		r_d.core_mem_stop = in_reset;
		r_d.ram_retain    = in_reset && !req_poc;
		r_d.poc_active  = 1'b1;
		r_d.lvd_stop    = in_reset && !r_d.lvd_own;
		r_d.periph_stop = in_reset;
		r_d.lvd_reset_n = !(in_reset && !r_d.lvd_own);
		r_d.wdt_reset = in_reset;
		r_d.pc_valid = !in_reset;
	end

	// one register for the whole state word
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// constants only, every control on its safe side
			r_q <= '{
				st:             rsc_pkg::RSC_ST_RESET,
				wait_cnt:       8'h00,
				cause:          rsc_pkg::RSC_CAUSE_RESET,
				lvd_own:        1'b0,
				stop_rst:       1'b0,
				stop_exit:      1'b0,
				vec_start:      1'b0,
				chip_reset_n:   1'b0,
				pins_hiz:       1'b1,
				osc_stop:       4'h0,
				ext_clk_ignore: 1'b0,
				xtal_in:        1'b1,
				cpu_clk_stop:   1'b1,
				core_mem_stop:  1'b1,
				ram_retain:     1'b0,
				poc_active:     1'b1,
				lvd_stop:       1'b1,
				lvd_reset_n:    1'b0,
				periph_stop:    1'b1,
				wdt_reset:      1'b1,
				pc_valid:       1'b0
			};
		end else begin
			r_q <= r_d;
		end
	end

	assign vec.start = r_q.vec_start;

	// byte fetch of the start address; the pc output shows each byte as soon as it is loaded
	rsc_vector_fetch u_vector_fetch (
		.i_clk       (i_core_clk),
		.i_rst_n     (rst_n),
		.vec         (vec),
		.o_mem_rd    (o_mem_rd),
		.o_mem_addr  (o_mem_addr),
		.i_mem_rdata (i_mem_rdata)
	);

	// outputs straight from the state word: chip reset and pin float
	assign o_chip_reset_n    = r_q.chip_reset_n;
	assign o_pins_hiz        = r_q.pins_hiz;

	// clock controls
	assign o_osc_stop        = r_q.osc_stop;
	assign o_ext_clk_ignore  = r_q.ext_clk_ignore;
	assign o_xtal_pins_input = r_q.xtal_in;
	assign o_cpu_clk_stop    = r_q.cpu_clk_stop;

	// core and memory
	assign o_core_mem_stop   = r_q.core_mem_stop;
	assign o_ram_retain      = r_q.ram_retain;

	// supply detectors
	assign o_poc_active      = r_q.poc_active;
	assign o_lvd_stop        = r_q.lvd_stop;
	assign o_lvd_reset_n     = r_q.lvd_reset_n;

	// peripherals and watchdog
	assign o_periph_stop     = r_q.periph_stop;
	assign o_wdt_reset       = r_q.wdt_reset;

	// standby exit; memory keep is a level until the next reset from run
	assign o_stop_exit       = r_q.stop_exit;
	assign o_mem_keep        = r_q.stop_rst;

	// start address, shown valid only once the core runs
	assign o_pc_valid        = r_q.pc_valid;
	assign o_pc              = vec.pc;

	// reset cause flags
	assign o_reset_cause     = r_q.cause;

endmodule : rsc_system_reset_controller
`default_nettype wire

// file: verification/rsc_sys_reset_asserts.sv
// port checker for the system reset controller
`timescale 1ns/1ps
`default_nettype none
module rsc_sys_reset_asserts (
	input wire logic        i_core_clk,
	input wire logic        i_resetn,
	input wire logic        i_ext_reset_n,
	input wire logic        i_wdt_overflow,
	input wire logic        i_poc_below,
	input wire logic        i_lvd_below,
	input wire logic        i_op_exec,
	input wire logic [7:0]  i_op_code,
	input wire logic        i_debug_emul,
	input wire logic        i_stop_mode,
	input wire logic        o_chip_reset_n,
	input wire logic        o_pins_hiz,
	input wire logic [3:0]  o_osc_stop,
	input wire logic        o_cpu_clk_stop,
	input wire logic        o_wdt_reset,
	input wire logic        o_lvd_reset_n,
	input wire logic        o_stop_exit,
	input wire logic        o_mem_keep,
	input wire logic        o_pc_valid,
	input wire logic        o_mem_rd,
	input wire logic [15:0] o_mem_addr
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	logic [1:0] up_q;
	logic [7:0] quiet_q;
	wire        ill = i_op_exec && i_op_code == 8'hff && !i_debug_emul;
	wire        other = !i_ext_reset_n || i_wdt_overflow || i_poc_below;
	wire        up = up_q == 2'h3;
	// settle count after reset, and run of cycles free of any request
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			up_q <= 2'h0;
			quiet_q <= 8'h00;
		end else begin
			up_q <= up ? up_q : up_q + 2'h1;
			quiet_q <= (other || ill || i_lvd_below) ? 8'h00 : quiet_q + {7'h0, quiet_q != 8'hff};
		end
	end
	a_pin_holds: assert property (up && !i_ext_reset_n [*2]
		|=> !o_chip_reset_n && o_osc_stop == 4'hf) else $error("pin reset not held");
	a_span_outputs: assert property (up |-> o_pins_hiz == !o_chip_reset_n
		&& o_cpu_clk_stop == !o_chip_reset_n && o_pc_valid == o_chip_reset_n)
		else $error("reset span outputs disagree");
	a_release_wait: assert property ($rose(o_chip_reset_n) |-> quiet_q >= 8'd40)
		else $error("released before the stabilization wait");
	a_release_bound: assert property (quiet_q == 8'd56 |-> o_chip_reset_n)
		else $error("no automatic release");
	a_vector_order: assert property ($rose(o_mem_rd) |-> o_mem_addr == 16'h0000
		##1 o_mem_rd && o_mem_addr == 16'h0001 ##1 !o_mem_rd) else $error("bad vector reads");
	a_illegal_op: assert property (up && o_chip_reset_n && ill |=> !o_chip_reset_n)
		else $error("illegal opcode gave no reset");
	a_debug_block: assert property (o_chip_reset_n && i_op_exec && i_debug_emul
		&& !other && !i_lvd_below |=> o_chip_reset_n) else $error("reset under emulation");
	a_wdt_reset: assert property (up && i_wdt_overflow |=> !o_chip_reset_n
		&& o_wdt_reset) else $error("watchdog reset missing");
	a_lvd_alive: assert property (o_chip_reset_n && i_lvd_below && !other && !ill
		|=> o_lvd_reset_n) else $error("detector reset by own request");
	a_stop_exit: assert property (up && o_chip_reset_n && i_stop_mode
		&& i_wdt_overflow |=> o_stop_exit && o_mem_keep ##1 !o_stop_exit)
		else $error("stop exit pulse wrong");
	// main scenarios reached
	c_release: cover property ($rose(o_chip_reset_n));
	c_stop: cover property (o_stop_exit);
	c_lvd: cover property (!o_chip_reset_n && o_lvd_reset_n);
endmodule : rsc_sys_reset_asserts
`default_nettype wire

// file: verification/rsc_board_reset.sv
// board reset source: a press holds the reset pin low for a fixed time
`timescale 1ns/1ps
`default_nettype none
module rsc_board_reset #(
	parameter int LOW_CYC = 400
) (
	input  wire logic i_clk,
	input  wire logic i_press,
	output logic      o_reset_n
);
	int cnt_q = 0;
	// hold pin low: 400 cycles of 25 ns make the minimum
	always @(posedge i_clk) begin
		if (i_press)
			cnt_q <= LOW_CYC;
		else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
	end
	// pin is high whenever the hold count is zero, so it idles high between presses
	assign o_reset_n = cnt_q == 0;
endmodule : rsc_board_reset
`default_nettype wire

// file: verification/tb_top.sv
// top testbench: board source, vector memory and scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        i_core_clk = 0, i_resetn = 0, i_wdt_overflow = 0, i_poc_below = 0;
	logic        i_lvd_below = 0, i_op_exec = 0, i_debug_emul = 0, i_stop_mode = 0;
	logic        i_cause_read = 0, press = 0;
	logic [7:0]  i_op_code = 8'h00, i_mem_rdata = 8'h00, o_reset_cause;
	logic [15:0] o_pc, o_mem_addr;
	logic [3:0]  o_osc_stop;
	logic        o_chip_reset_n, o_pins_hiz, o_ext_clk_ignore, o_xtal_pins_input;
	logic        o_cpu_clk_stop, o_core_mem_stop, o_ram_retain, o_poc_active, o_lvd_stop;
	logic        o_lvd_reset_n, o_periph_stop, o_wdt_reset, o_stop_exit, o_mem_keep;
	logic        o_pc_valid, o_mem_rd;
	wire logic   i_ext_reset_n;
	int          fails = 0, compares = 0, cyc = 0;
	rsc_board_reset u_board (.i_clk(i_core_clk), .i_press(press), .o_reset_n(i_ext_reset_n));
	rsc_system_reset_controller dut (.i_core_clk, .i_resetn, .i_ext_reset_n, .i_wdt_overflow,
		.i_poc_below, .i_lvd_below, .i_op_exec, .i_op_code, .i_debug_emul, .i_stop_mode,
		.i_cause_read, .i_mem_rdata, .o_chip_reset_n, .o_pins_hiz, .o_osc_stop,
		.o_ext_clk_ignore, .o_xtal_pins_input, .o_cpu_clk_stop, .o_core_mem_stop,
		.o_ram_retain, .o_poc_active, .o_lvd_stop, .o_lvd_reset_n, .o_periph_stop,
		.o_wdt_reset, .o_stop_exit, .o_mem_keep, .o_pc_valid, .o_pc, .o_mem_rd, .o_mem_addr,
		.o_reset_cause);
	// clock, 25 ns period
	initial forever #12.5 i_core_clk = ~i_core_clk;
	// vector memory answers in the cycle of the strobe, sampled at its end;
	// the bus toggles when nobody reads, so a fetch a cycle off shows up
	always @(posedge i_core_clk) begin
		#1;
		i_mem_rdata = !o_mem_rd ? ~i_mem_rdata : (o_mem_addr[0] ? 8'h9a : 8'h5c);
	end
	// hang guard, well above the total run length
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : step
	task automatic chk_b(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_b
	task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v
	// bounded wait for run, then the start address and cause flags
	task automatic run_ok(input logic [7:0] cause);
		int n;
		n = 0;
		while (o_chip_reset_n !== 1'h1 && n < 600) begin
			step(1);
			n++;
		end
		chk_b("pc_valid", 1'h1, o_pc_valid);
		chk_v("pc", 16'h9a5c, o_pc);
		chk_b("hiz", 1'h0, o_pins_hiz);
		chk_v("cause", {8'h00, cause}, {8'h00, o_reset_cause});
	endtask : run_ok
	task automatic pulse_req(ref logic sig);
		sig = 1'h1;
		step(1);
		sig = 1'h0;
	endtask : pulse_req
	task automatic t_illegal();
		i_op_code = 8'hff;
		i_debug_emul = 1'h1;
		pulse_req(i_op_exec);
		step(2);
		chk_b("emul", 1'h1, o_chip_reset_n);
		i_debug_emul = 1'h0;
		i_op_code = 8'hfe;
		pulse_req(i_op_exec);
		step(2);
		chk_b("legal", 1'h1, o_chip_reset_n);
		i_op_code = 8'hff;
		pulse_req(i_op_exec);
		chk_b("ill", 1'h0, o_chip_reset_n);
		run_ok(8'h80);
	endtask : t_illegal
	task automatic t_wdt();
		pulse_req(i_wdt_overflow);
		chk_b("wdt_rst", 1'h1, o_wdt_reset);
		chk_b("ram", 1'h1, o_ram_retain);
		run_ok(8'h90);
		pulse_req(i_cause_read);
		step(1);
		chk_v("read", 16'h0000, {8'h00, o_reset_cause});
	endtask : t_wdt
	task automatic t_supply();
		i_lvd_below = 1'h1;
		step(2);
		chk_b("lvd_run", 1'h1, o_lvd_reset_n);
		chk_b("lvd_own", 1'h0, o_lvd_stop);
		step(60);
		chk_b("lvd_hold", 1'h0, o_chip_reset_n);
		i_lvd_below = 1'h0;
		run_ok(8'h01);
		i_poc_below = 1'h1;
		step(2);
		chk_b("poc_ram", 1'h0, o_ram_retain);
		chk_b("lvd_stop", 1'h0, o_lvd_reset_n);
		chk_b("lvd_halt", 1'h1, o_lvd_stop);
		chk_b("poc_on", 1'h1, o_poc_active);
		i_poc_below = 1'h0;
		run_ok(8'h00);
	endtask : t_supply
	task automatic t_stop();
		i_stop_mode = 1'h1;
		pulse_req(i_wdt_overflow);
		chk_b("exit", 1'h1, o_stop_exit);
		step(1);
		i_stop_mode = 1'h0;
		chk_b("exit_end", 1'h0, o_stop_exit);
		chk_b("keep", 1'h1, o_mem_keep);
		run_ok(8'h10);
	endtask : t_stop
	task automatic t_pin();
		pulse_req(press);
		step(3);
		chk_v("osc", 16'h000f, {12'h000, o_osc_stop});
		chk_b("ext_clk", 1'h1, o_ext_clk_ignore);
		chk_b("xtal", 1'h1, o_xtal_pins_input);
		chk_b("periph", 1'h1, o_periph_stop);
		chk_b("core", 1'h1, o_core_mem_stop);
		step(390);
		chk_b("held", 1'h0, o_chip_reset_n);
		run_ok(8'h00);
		chk_b("nokeep", 1'h0, o_mem_keep);
	endtask : t_pin
	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// main sequence
	initial begin
		step(12);
		i_resetn = 1'h1;
		run_ok(8'h00);
		t_illegal();
		t_wdt();
		t_supply();
		t_stop();
		t_pin();
		results();
	end
endmodule : tb_top
bind rsc_system_reset_controller rsc_sys_reset_asserts u_chk (.i_core_clk, .i_resetn,
	.i_ext_reset_n, .i_wdt_overflow, .i_poc_below, .i_lvd_below, .i_op_exec, .i_op_code,
	.i_debug_emul, .i_stop_mode, .o_chip_reset_n, .o_pins_hiz, .o_osc_stop, .o_cpu_clk_stop,
	.o_wdt_reset, .o_lvd_reset_n, .o_stop_exit, .o_mem_keep, .o_pc_valid, .o_mem_rd,
	.o_mem_addr);
`default_nettype wire
